// *** include/bucket_pkg.sv ***
/*
 Package for the input activity leaky bucket: register map, reset values, timing.
 Assumes a 25 MHz system clock and a classic Wishbone register bus.
*/
package bucket_pkg;
   localparam int unsigned CLK_HZ          = 25_000_000;
   localparam int unsigned CYCLE_MS        = 128;
   localparam int unsigned CYCLE_CLKS      = CLK_HZ / 1000 * CYCLE_MS;
   localparam int unsigned ADDR_W          = 10;
   localparam int unsigned DATA_W          = 32;
   localparam int unsigned COUNT_W         = 8;
   localparam int unsigned RATE_W          = 2;
   localparam logic [7:0]  IDX_LEAK_RATE   = 8'h57;
   localparam logic [7:0]  IDX_LIMIT       = 8'h56;
   localparam logic [7:0]  IDX_UPPER       = 8'h60;
   localparam logic [7:0]  IDX_STATUS      = 8'h61;
   localparam logic [ADDR_W-1:0] ADDR_LEAK_RATE = {IDX_LEAK_RATE, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_LIMIT     = {IDX_LIMIT, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_UPPER     = {IDX_UPPER, 2'b00};
   localparam logic [ADDR_W-1:0] ADDR_STATUS    = {IDX_STATUS, 2'b00};
   localparam logic [RATE_W-1:0]  RESET_LEAK_RATE = 2'h1;
   localparam logic [COUNT_W-1:0] RESET_LIMIT     = 8'h08;
   localparam logic [COUNT_W-1:0] RESET_UPPER     = 8'h06;
   localparam int unsigned STATUS_ALARM_BIT = 8;
   localparam int unsigned STATUS_COUNT_LSB = 0;
endpackage

// *** include/bucket_if.sv ***
/*
 Interface between the bucket top and its cycle timer.
 Assumes both ends share one clock.
*/
`timescale 1ns/10ps
interface bucket_if;
   logic cycle_tick;
   modport timer (output cycle_tick);
   modport user  (input  cycle_tick);
endinterface // bucket_if

// *** verilog/bucket_cycle_timer.sv ***
/*
 Free running timer that pulses once per bucket cycle.
 Assumes rst_n is asynchronous active low and clock is the system clock.
*/
`timescale 1ns/10ps
module bucket_cycle_timer
   import bucket_pkg::*;
#(
   parameter int unsigned PERIOD_CLKS = CYCLE_CLKS
) (
   input  wire logic clock,
   input  wire logic rst_n,
   bucket_if.timer   tmr
);
   // Elaboration check: the 28-bit counter bounds the period
   if (PERIOD_CLKS < 2 || PERIOD_CLKS > 32'h0fff_ffff) begin : g_bad_period
      $error("bad period");
   end

   logic [27:0] count_reg;
   logic        tick_reg;
   wire         at_end = (count_reg == 28'(PERIOD_CLKS - 1));

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 28'h0;
         tick_reg  <= 1'b0;
      end else begin
         count_reg <= at_end ? 28'h0 : count_reg + 28'h1;
         tick_reg  <= at_end;
      end
   end

   assign tmr.cycle_tick = tick_reg;
endmodule // bucket_cycle_timer

// *** verilog/leaky_bucket.sv ***
/*
 Leaky bucket accumulator for input activity, configuration one, with Wishbone slave.
 Assumes fault_in comes from off-domain monitor logic, held across a bucket cycle.
*/
// Behaviour
// - Each bucket cycle with a fault seen adds one to the count, up to the bucket limit.
// - Each leak period of 1, 2, 4 or 8 fault-free cycles subtracts one, down to zero.
// - Leak codes 00..11 mean one count per 128, 256, 512, 1024 ms.
// - The count saturates at the programmed bucket limit.
// - Fastest leak setting gives one decrement chance per bucket cycle.
// - Count reaching the upper threshold raises the inactivity alarm.
`timescale 1ns/10ps
module leaky_bucket
   import bucket_pkg::*;
#(
   parameter int unsigned PERIOD_CLKS = CYCLE_CLKS
) (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              fault_in,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [DATA_W-1:0] wb_dat_i,
   output logic      [DATA_W-1:0] wb_dat_o,
   output logic                   wb_ack_o,
   output logic                   alarm
);
   if (PERIOD_CLKS < 2) begin : g_bad_period
      $error("period too short");
   end

   bucket_if bif ();

   bucket_cycle_timer #(
      .PERIOD_CLKS (PERIOD_CLKS)
   ) u_timer (
      .clock (clock),
      .rst_n (rst_n),
      .tmr   (bif.timer)
   );

   // Fault pin is asynchronous to this clock
   logic sync1_reg;
   logic sync2_reg;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else begin
         sync1_reg <= fault_in;
         sync2_reg <= sync1_reg;
      end
   end

   // Any fault within the cycle is latched until the cycle end
   logic seen_reg;
   wire  tick = bif.cycle_tick;
   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) seen_reg <= 1'b0;
      // Restart empty at the tick so one sample is not counted in two cycles
      else        seen_reg <= tick ? 1'b0 : (seen_reg | sync2_reg);
   end
   wire cycle_fault = seen_reg | sync2_reg;

   logic [RATE_W-1:0]  leak_rate_reg;
   logic [COUNT_W-1:0] limit_reg;
   logic [COUNT_W-1:0] upper_reg;
   logic [COUNT_W-1:0] count_reg;
   logic [COUNT_W-1:0] count_next;
   logic [2:0]         quiet_reg;
   logic [2:0]         quiet_next;
   logic               alarm_reg;

   function automatic logic [2:0] leak_last(input logic [RATE_W-1:0] code);
      // Code n means a leak every 2**n bucket cycles
      unique case (code)
         2'b00: leak_last = 3'd0;
         2'b01: leak_last = 3'd1;
         2'b10: leak_last = 3'd3;
         2'b11: leak_last = 3'd7;
      endcase
   endfunction

   wire period_done = (quiet_reg == leak_last(leak_rate_reg));

   always_comb begin
      count_next = count_reg;
      quiet_next = quiet_reg;
      if (tick) begin
         if (cycle_fault) begin
            quiet_next = 3'd0;
            if (count_reg < limit_reg)
               count_next = count_reg + 8'h01;
            else
               count_next = limit_reg;
         end else if (period_done) begin
            quiet_next = 3'd0;
            if (count_reg != 8'h00)
               count_next = count_reg - 8'h01;
         end else begin
            quiet_next = quiet_reg + 3'd1;
         end
      end
   end

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         count_reg <= 8'h00;
         quiet_reg <= 3'd0;
         alarm_reg <= 1'b0;
      end else begin
         count_reg <= count_next;
         quiet_reg <= quiet_next;
         alarm_reg <= (count_next >= upper_reg);
      end
   end

   // Wishbone: one wait state, ack drops in the cycle after it is given
   wire req  = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   wire wr0  = req & wb_we_i & wb_sel_i[0];
   wire sel_rate   = (wb_adr_i == ADDR_LEAK_RATE);
   wire sel_limit  = (wb_adr_i == ADDR_LIMIT);
   wire sel_upper  = (wb_adr_i == ADDR_UPPER);
   wire sel_status = (wb_adr_i == ADDR_STATUS);

   wire [DATA_W-1:0] rd_rate   = {30'h0, leak_rate_reg};
   wire [DATA_W-1:0] rd_limit  = {24'h0, limit_reg};
   wire [DATA_W-1:0] rd_upper  = {24'h0, upper_reg};
   wire [DATA_W-1:0] rd_status = {23'h0, alarm_reg, count_reg};
   wire [DATA_W-1:0] rd_mux    = sel_rate   ? rd_rate   :
                                 sel_limit  ? rd_limit  :
                                 sel_upper  ? rd_upper  :
                                 sel_status ? rd_status : 32'h0;

   always_ff @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         leak_rate_reg <= RESET_LEAK_RATE;
         limit_reg     <= RESET_LIMIT;
         upper_reg     <= RESET_UPPER;
         wb_ack_o      <= 1'b0;
         wb_dat_o      <= 32'h0;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= req ? rd_mux : 32'h0;
         if (wr0 && sel_rate)  leak_rate_reg <= wb_dat_i[1:0];
         if (wr0 && sel_limit) limit_reg     <= wb_dat_i[7:0];
         if (wr0 && sel_upper) upper_reg     <= wb_dat_i[7:0];
      end
   end

   assign alarm = alarm_reg;
endmodule // leaky_bucket

// *** sim/leaky_bucket_sva.sv ***
/* Port checker for the leaky bucket.
 Assumes a bind from the testbench top file. */
`timescale 1ns/10ps
module leaky_bucket_sva
   import bucket_pkg::*;
(
   input wire logic              clock,
   input wire logic              rst_n,
   input wire logic              wb_cyc_i,
   input wire logic              wb_stb_i,
   input wire logic              wb_we_i,
   input wire logic [ADDR_W-1:0] wb_adr_i,
   input wire logic [DATA_W-1:0] wb_dat_o,
   input wire logic              wb_ack_o
);
   default clocking @(posedge clock); endclocking
   default disable iff (!rst_n);
   wire rd_ack = wb_ack_o && !wb_we_i;
   wire unmapped = !(wb_adr_i inside {ADDR_LEAK_RATE, ADDR_LIMIT, ADDR_UPPER, ADDR_STATUS});
   property p_answer; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_answer: assert property (p_answer) else $error("ack not one cycle pulse");
   property p_cause; wb_ack_o |-> $past(wb_cyc_i && wb_stb_i); endproperty
   a_cause: assert property (p_cause) else $error("ack without request");
   property p_idle; !wb_ack_o |-> wb_dat_o == '0; endproperty
   a_idle: assert property (p_idle) else $error("read data without ack");
   property p_rate; rd_ack && wb_adr_i == ADDR_LEAK_RATE |-> wb_dat_o[31:2] == '0; endproperty
   a_rate: assert property (p_rate) else $error("rate upper bits set");
   property p_limit; rd_ack && wb_adr_i == ADDR_LIMIT |-> wb_dat_o[31:8] == '0; endproperty
   a_limit: assert property (p_limit) else $error("limit wider than byte");
   property p_status; rd_ack && wb_adr_i == ADDR_STATUS |-> wb_dat_o[31:9] == '0; endproperty
   a_status: assert property (p_status) else $error("status junk bits");
   property p_unmap; rd_ack && unmapped |-> wb_dat_o == '0; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
endmodule // leaky_bucket_sva

// *** sim/tb_leaky_bucket.sv ***
/* Testbench for the leaky bucket: registers, fill, saturation, leak.
 Assumes a short bucket cycle of P clocks. */
`timescale 1ns/10ps
module tb_leaky_bucket import bucket_pkg::*; ;
   localparam int P = 20;
   logic              clock = 0, rst_n = 0, fault_in = 0, cyc = 0, stb = 0, we = 0;
   logic [ADDR_W-1:0] adr = '0;
   logic [3:0]        sel = '0;
   logic [DATA_W-1:0] dat = '0, dat_o, rd;
   logic              ack, alarm;
   int                fail_count = 0, checks = 0, cnt = 0;
   always #20 clock = ~clock;
   always @(posedge clock) if (rst_n) cnt <= cnt + 1;
   leaky_bucket #(.PERIOD_CLKS(P)) i_leaky_bucket (.clock, .rst_n, .fault_in, .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat),
      .wb_dat_o(dat_o), .wb_ack_o(ack), .alarm);
   task automatic chk(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
      checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   task automatic bus(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
                      input logic [3:0] s);
      int n;
      n = 0;
      @(posedge clock);
      {cyc, stb, we, adr, dat, sel} <= {2'b11, w, a, d, s};
      do @(posedge clock); while (ack !== 1'b1 && n++ < 16);
      if (n >= 16) fail_count++;
      rd = dat_o;
      {cyc, stb} <= 2'b00;
   endtask
   task automatic rdc(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e, input string nm);
      bus(1'b0, a, '0, 4'hf);
      chk(nm, e, rd);
   endtask
   task automatic mid(input int k);
      // Mid-cycle keeps clear of tick jitter and fault sync delay
      repeat (k) do @(posedge clock); while (cnt % P != 10);
   endtask
   task automatic t_regs;
      rdc(ADDR_LEAK_RATE, 32'h01, "rate");
      rdc(ADDR_LIMIT, 32'h08, "limit");
      bus(1'b1, ADDR_LEAK_RATE, 32'hff, 4'h1);
      bus(1'b1, ADDR_LEAK_RATE, 32'h00, 4'he);
      rdc(ADDR_LEAK_RATE, 32'h03, "rate");
      rdc(10'h3fc, 32'h00, "unmapped");
      rdc(ADDR_STATUS, 32'h00, "status");
      $display("test regs done");
   endtask
   task automatic t_fill;
      bus(1'b1, ADDR_LIMIT, 32'h03, 4'h1);
      bus(1'b1, ADDR_UPPER, 32'h02, 4'h1);
      mid(1);
      fault_in <= 1'b1;
      mid(2);
      rdc(ADDR_STATUS, 32'h102, "status");
      chk("alarm", 32'h1, {31'h0, alarm});
      mid(3);
      fault_in <= 1'b0;
      rdc(ADDR_STATUS, 32'h103, "status");
      $display("test fill done");
   endtask
   task automatic t_leak;
      bus(1'b1, ADDR_LEAK_RATE, 32'h02, 4'h1);
      mid(4);
      rdc(ADDR_STATUS, 32'h103, "status");
      mid(1);
      rdc(ADDR_STATUS, 32'h102, "status");
      bus(1'b1, ADDR_LEAK_RATE, 32'h00, 4'h1);
      mid(1);
      rdc(ADDR_STATUS, 32'h001, "status");
      chk("alarm", 32'h0, {31'h0, alarm});
      mid(3);
      rdc(ADDR_STATUS, 32'h000, "status");
      $display("test leak done");
   endtask
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   initial begin
      repeat (2) @(posedge clock);
      rst_n <= 1'b1;
      t_regs;
      t_fill;
      t_leak;
      wrap_up;
   end
   initial begin
      #100000;
      fail_count++;
      wrap_up;
   end
endmodule // tb_leaky_bucket
bind leaky_bucket leaky_bucket_sva i_leaky_bucket_sva (.clock, .rst_n, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o);
